//--- rtl/madc_control.sv
/*
  monitoring converter control registers, channel scan sequencer and byte-wide result readout.
  assumes a byte register port (address, write strobe, data) from the management-bus slave, and an
  analogue converter that takes a channel index with a start pulse and answers with a done pulse.
*/
module madc_control (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       nrst,
  // resets from the rest of the charger
  input  wire logic       regReset,
  input  wire logic       watchdogExpired,
  // charger state
  input  wire logic       tempCompOn,
  input  wire logic       doneEventMask,
  input  wire logic       oneShotRequest,
  // register port
  input  wire logic [7:0] regAddr,
  input  wire logic       regWrite,
  input  wire logic [7:0] regWdata,
  output logic      [7:0] regRdata,
  // analogue converter
  output logic      [2:0] convChannel,
  output logic            convStart,
  output logic      [1:0] sampleSpeed,
  input  wire logic       convDone,
  input  wire logic [15:0] convData,
  // status
  output logic            converterActive,
  output logic            convDonePulse
);

  typedef enum logic [1:0] {SCAN_IDLE, SCAN_PICK, SCAN_WAIT} madc_scan_t;

  logic [7:0]  ctrl_r;
  logic [7:0]  chan_r;
  madc_scan_t  state_r;
  logic [2:0]  chIdx_r;
  logic        armed_r;
  logic        donePulse_r;
  logic        running;
  logic        chOn;
  logic [3:0]  sampleValid;
  logic [15:0] iinResult;
  logic [15:0] ibatResult;
  logic [15:0] vinResult;
  logic [15:0] vbatResult;

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ctrl_r <= madc_pkg::CTRL_RESET;                                     // [R3] [R4]
    end else if (regReset) begin
      ctrl_r <= madc_pkg::CTRL_RESET;                                     // [R2]
    end else begin
      if (regWrite && regAddr == madc_pkg::ADDR_CTRL) begin
        ctrl_r <= regWdata & madc_pkg::CTRL_WMASK;
      end
      // watchdog wins over a write in the same cycle so software cannot miss the expiry
      if (watchdogExpired) begin
        ctrl_r[madc_pkg::BIT_EN] <= 1'b0;                                 // [R2]
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      chan_r <= madc_pkg::CHAN_RESET;                                     // [R8]
    end else if (regReset) begin
      chan_r <= madc_pkg::CHAN_RESET;                                     // [R8]
    end else if (regWrite && regAddr == madc_pkg::ADDR_CHAN) begin
      chan_r <= regWdata & madc_pkg::CHAN_WMASK;                          // [R7]
    end
  end

  assign running         = ctrl_r[madc_pkg::BIT_EN] | tempCompOn;        // [R1]
  assign converterActive = running;
  // reserved code 11b is passed through; the analogue side treats it as 13 bit
  assign sampleSpeed     = ctrl_r[madc_pkg::BIT_SAMPLE_HI:madc_pkg::BIT_SAMPLE_LO]; // [R4]

  // ----------------------------------------------------------------
  // channel scan
  // ----------------------------------------------------------------
  // bit 3 and bit 0 hold no channel; the write mask doubles as the list of real channels, so
  // those indices are always skipped, whatever the stored bit says after a write
  assign chOn = madc_pkg::CHAN_WMASK[chIdx_r] && !chan_r[chIdx_r];        // [R7] [R17]

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      armed_r <= 1'b0;
    end else if (regReset || !running) begin
      armed_r <= 1'b0;
    end else if (oneShotRequest) begin
      armed_r <= 1'b1;                                                    // [R16]
    end else if (state_r == SCAN_PICK && chIdx_r == 3'd0) begin
      armed_r <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_r <= SCAN_IDLE;
      chIdx_r <= 3'd7;
    end else if (regReset || !running) begin
      state_r <= SCAN_IDLE;                                               // [R1]
      chIdx_r <= 3'd7;
    end else begin
      case (state_r)
        SCAN_IDLE: begin
          chIdx_r <= 3'd7;
          if (!ctrl_r[madc_pkg::BIT_RATE] || armed_r) state_r <= SCAN_PICK; // [R3]
        end
        SCAN_PICK: begin
          if (chOn) begin
            state_r <= SCAN_WAIT;
          end else if (chIdx_r == 3'd0) begin
            state_r <= SCAN_IDLE;                                         // [R16] [R17]
          end else begin
            chIdx_r <= chIdx_r - 3'd1;                                    // [R17]
          end
        end
        SCAN_WAIT: begin
          if (convDone) begin
            if (chIdx_r == 3'd0) begin
              state_r <= SCAN_IDLE;
            end else begin
              chIdx_r <= chIdx_r - 3'd1;
              state_r <= SCAN_PICK;
            end
          end
        end
        default: state_r <= SCAN_IDLE;
      endcase
    end
  end

  assign convStart   = (state_r == SCAN_PICK) && chOn;
  assign convChannel = chIdx_r;

  // done pulse at the end of a one-shot pass, whether or not any channel converted
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      donePulse_r <= 1'b0;
    end else begin
      donePulse_r <= ctrl_r[madc_pkg::BIT_RATE] && !doneEventMask && chIdx_r == 3'd0
                  && ((state_r == SCAN_WAIT && convDone) || (state_r == SCAN_PICK && !chOn)); // [R15]
    end
  end
  assign convDonePulse = donePulse_r;

  // ----------------------------------------------------------------
  // result slots
  // ----------------------------------------------------------------
  always_comb begin
    sampleValid = 4'b0000;
    if (state_r == SCAN_WAIT && convDone) begin
      case (chIdx_r)
        3'(madc_pkg::CH_IIN):  sampleValid[0] = 1'b1;
        3'(madc_pkg::CH_BATTERY_CURRENT): sampleValid[1] = 1'b1;
        3'(madc_pkg::CH_VIN):  sampleValid[2] = 1'b1;
        3'(madc_pkg::CH_VBAT): sampleValid[3] = 1'b1;
        default:               sampleValid = 4'b0000;
      endcase
    end
  end

  // both bytes load in one edge; the byte reads are not latched, so reads across an update see halves of two samples
  madc_result #(.SIGNED_FMT(1'b1), .LIMIT_MIN(madc_pkg::IIN_MIN), .LIMIT_MAX(madc_pkg::IIN_MAX)) uIin ( // [R10] [R16]
    .clock          (clock),
    .nrst           (nrst),
    .softReset      (regReset),
    .sampleValid    (sampleValid[0]),
    .sampleIn       (convData),
    .averagingOn    (ctrl_r[madc_pkg::BIT_AVG]),
    .averageSeedSel (ctrl_r[madc_pkg::BIT_SEED]),
    .result         (iinResult)
  );
  madc_result #(.SIGNED_FMT(1'b1), .LIMIT_MIN(madc_pkg::BATTERY_CURRENT_MIN), .LIMIT_MAX(madc_pkg::BATTERY_CURRENT_MAX)) uIbat ( // [R12]
    .clock          (clock),
    .nrst           (nrst),
    .softReset      (regReset),
    .sampleValid    (sampleValid[1]),
    .sampleIn       (convData),
    .averagingOn    (ctrl_r[madc_pkg::BIT_AVG]),
    .averageSeedSel (ctrl_r[madc_pkg::BIT_SEED]),
    .result         (ibatResult)
  );
  madc_result #(.SIGNED_FMT(1'b0), .LIMIT_MIN(madc_pkg::RESULT_RESET), .LIMIT_MAX(madc_pkg::VOLT_MAX)) uVin ( // [R13]
    .clock          (clock),
    .nrst           (nrst),
    .softReset      (regReset),
    .sampleValid    (sampleValid[2]),
    .sampleIn       (convData),
    .averagingOn    (ctrl_r[madc_pkg::BIT_AVG]),
    .averageSeedSel (ctrl_r[madc_pkg::BIT_SEED]),
    .result         (vinResult)
  );
  madc_result #(.SIGNED_FMT(1'b0), .LIMIT_MIN(madc_pkg::RESULT_RESET), .LIMIT_MAX(madc_pkg::VOLT_MAX)) uVbat ( // [R14]
    .clock          (clock),
    .nrst           (nrst),
    .softReset      (regReset),
    .sampleValid    (sampleValid[3]),
    .sampleIn       (convData),
    .averagingOn    (ctrl_r[madc_pkg::BIT_AVG]),
    .averageSeedSel (ctrl_r[madc_pkg::BIT_SEED]),
    .result         (vbatResult)
  );

  // ----------------------------------------------------------------
  // readback
  // ----------------------------------------------------------------
  always_comb begin
    case (regAddr)
      madc_pkg::ADDR_CTRL:    regRdata = ctrl_r;
      madc_pkg::ADDR_CHAN:    regRdata = chan_r & madc_pkg::CHAN_WMASK;
      madc_pkg::ADDR_IIN_LO:  regRdata = iinResult[7:0];                  // [R11]
      madc_pkg::ADDR_IIN_HI:  regRdata = iinResult[15:8];                 // [R11]
      madc_pkg::ADDR_BATTERY_CURRENT_LO: regRdata = ibatResult[7:0];
      madc_pkg::ADDR_BATTERY_CURRENT_HI: regRdata = ibatResult[15:8];
      madc_pkg::ADDR_VIN_LO:  regRdata = vinResult[7:0];
      madc_pkg::ADDR_VIN_HI:  regRdata = vinResult[15:8];
      madc_pkg::ADDR_VBAT_LO: regRdata = vbatResult[7:0];
      madc_pkg::ADDR_VBAT_HI: regRdata = vbatResult[15:8];
      default:                regRdata = 8'h00;
    endcase
  end

endmodule // madc_control

//--- shared/madc_pkg.sv
/*
  constants for the monitoring converter control and result block: register offsets, field positions,
  reset values, clamp limits and channel indices.
  assumes a byte-wide register port driven by the management-bus slave elsewhere in the chip.
*/
// How it works
// R1 - the converter runs when its enable bit is 1 or temperature compensation is on, and is off otherwise.
// R2 - the converter enable bit clears on a register reset and on a management-bus watchdog expiry.
// R3 - the rate bit picks continuous conversion at 0 and one-shot at 1, and resets to one-shot.
// R4 - the two-bit sample field picks 15, 14 or 13 bit resolution, 11b is reserved, and it resets to 10b.
// R5 - the averaging bit makes results report the latest value at 0 and a running average at 1.
// R6 - the seed bit starts the average from the held result at 0 or from a fresh conversion at 1.
// R7 - each channel disable bit excludes its channel from conversion when 1.
// R8 - software keeps the feedback channel disabled while charging, and that disable bit resets to 1.
// R9 - software disables the battery-current channel while the battery load is on.
// R10 - the input-current result is signed 16-bit, clamped to 9e58h..61a8h.
// R11 - each result reads as two bytes, high byte at the higher address, low byte at the lower one.
// R12 - the battery-current result is signed 16-bit, clamped to d8f0h..2710h.
// R13 - the input-voltage result is unsigned, clamped low at 0 and spanning up to 7530h.
// R14 - the battery-voltage result is unsigned, clamped low at 0 and spanning up to 7530h.
// R15 - in one-shot mode a finished conversion pulses the done output unless the done mask is set.
// R16 - one-shot converts each enabled channel once, updates both bytes together, then stops.
// R17 - continuous mode cycles over enabled channels, and disabled channels keep their result.
package madc_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL      = 8'h2b;
  localparam logic [7:0] ADDR_CHAN      = 8'h2c;
  localparam logic [7:0] ADDR_IIN_LO    = 8'h2d;
  localparam logic [7:0] ADDR_IIN_HI    = 8'h2e;
  localparam logic [7:0] ADDR_BATTERY_CURRENT_LO   = 8'h2f;
  localparam logic [7:0] ADDR_BATTERY_CURRENT_HI   = 8'h30;
  localparam logic [7:0] ADDR_VIN_LO    = 8'h31;
  localparam logic [7:0] ADDR_VIN_HI    = 8'h32;
  localparam logic [7:0] ADDR_VBAT_LO   = 8'h33;
  localparam logic [7:0] ADDR_VBAT_HI   = 8'h34;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int         BIT_EN         = 7;
  localparam int         BIT_RATE       = 6;
  localparam int         BIT_SAMPLE_HI  = 5;
  localparam int         BIT_SAMPLE_LO  = 4;
  localparam int         BIT_AVG        = 3;
  localparam int         BIT_SEED       = 2;
  localparam logic [7:0] CTRL_WMASK     = 8'hfc;
  localparam logic [7:0] CHAN_WMASK     = 8'hf6;
  localparam logic [7:0] CTRL_RESET     = 8'h60;
  localparam logic [7:0] CHAN_RESET     = 8'h0a;

  // channel disable bit positions, also the scan index of each channel
  localparam int         CH_IIN         = 7;
  localparam int         CH_BATTERY_CURRENT        = 6;
  localparam int         CH_VIN         = 5;
  localparam int         CH_VBAT        = 4;
  localparam int         CH_THERM       = 2;
  localparam int         CH_FB          = 1;

  // ----------------------------------------------------------------
  // clamp limits
  // ----------------------------------------------------------------
  localparam logic [15:0] IIN_MIN       = 16'h9e58;
  localparam logic [15:0] IIN_MAX       = 16'h61a8;
  localparam logic [15:0] BATTERY_CURRENT_MIN      = 16'hd8f0;
  localparam logic [15:0] BATTERY_CURRENT_MAX      = 16'h2710;
  localparam logic [15:0] VOLT_MAX      = 16'h7530;

  localparam logic [15:0] RESULT_RESET  = 16'h0000;

endpackage

//--- rtl/madc_result.sv
/*
  one result slot: clamps a raw sample, optionally averages it, and holds the 16-bit result.
  assumes sampleValid is a one-cycle strobe aligned with sampleIn.
*/
module madc_result #(
  parameter bit          SIGNED_FMT = 1'b0,
  parameter logic [15:0] LIMIT_MIN  = 16'h0000,
  parameter logic [15:0] LIMIT_MAX  = 16'h7530
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        softReset,
  // sample in
  input  wire logic        sampleValid,
  input  wire logic [15:0] sampleIn,
  input  wire logic        averagingOn,
  input  wire logic        averageSeedSel,
  // result out
  output logic      [15:0] result
);

  logic [15:0] result_r;
  logic        seeded_r;
  logic [15:0] clamped;
  logic [16:0] sum;

  // ----------------------------------------------------------------
  // clamp
  // ----------------------------------------------------------------
  always_comb begin
    clamped = sampleIn;
    if (SIGNED_FMT) begin
      if ($signed(sampleIn) < $signed(LIMIT_MIN)) clamped = LIMIT_MIN;    // [R10] [R12]
      if ($signed(sampleIn) > $signed(LIMIT_MAX)) clamped = LIMIT_MAX;    // [R10] [R12]
    end else begin
      if (sampleIn[15]) clamped = LIMIT_MIN;                              // [R13] [R14]
      else if (sampleIn > LIMIT_MAX) clamped = LIMIT_MAX;
    end
  end

  // two-point running average, sign-extended so signed results stay exact
  assign sum = (SIGNED_FMT ? {result_r[15], result_r} : {1'b0, result_r})
             + (SIGNED_FMT ? {clamped[15], clamped} : {1'b0, clamped});

  // ----------------------------------------------------------------
  // result storage
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      result_r <= 16'h0000;
      seeded_r <= 1'b0;
    end else if (softReset) begin
      result_r <= 16'h0000;
      seeded_r <= 1'b0;
    end else if (sampleValid) begin
      if (!averagingOn) begin
        result_r <= clamped;                                              // [R5]
        seeded_r <= 1'b0;
      end else if (!seeded_r && averageSeedSel) begin
        result_r <= clamped;                                              // [R6]
        seeded_r <= 1'b1;
      end else begin
        result_r <= sum[16:1];                                            // [R5] [R6]
        seeded_r <= 1'b1;
      end
    end
  end

  assign result = result_r;

endmodule // madc_result

//--- dv/madc_control_properties.sv
/*
  port checker for the converter control block, bound to it at the foot of this file.
  assumes one clock domain and the asynchronous active-low reset of the block.
*/
module madc_control_properties (
  // clock and reset
  input wire logic       clock,
  input wire logic       nrst,
  // causes
  input wire logic       regReset,
  input wire logic       watchdogExpired,
  input wire logic       tempCompOn,
  input wire logic       doneEventMask,
  input wire logic [7:0] regAddr,
  input wire logic       regWrite,
  input wire logic [7:0] regWdata,
  // effects
  input wire logic [7:0] regRdata,
  input wire logic       convStart,
  input wire logic [1:0] sampleSpeed,
  input wire logic       converterActive,
  input wire logic       convDonePulse
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  // a register reset in the same cycle overrides the write
  wire ctrlWr = regWrite && (regAddr == madc_pkg::ADDR_CTRL) && !regReset;

  a_enable_turns_on: assert property (ctrlWr && regWdata[7] && !watchdogExpired |=> converterActive)
    else $error("converter not active after enable write");
  a_temp_comp_runs: assert property (tempCompOn |-> converterActive)
    else $error("temperature compensation did not force the converter on");
  a_watchdog_stops: assert property (watchdogExpired |=> !converterActive || tempCompOn)
    else $error("watchdog expiry left the converter enabled");
  a_regreset_stops: assert property (regReset |=> !converterActive || tempCompOn)
    else $error("register reset left the converter enabled");
  a_speed_written: assert property (ctrlWr |=> sampleSpeed == $past(regWdata[5:4]))
    else $error("sample speed does not follow the written field");
  a_speed_reset: assert property (regReset |=> sampleSpeed == 2'h2)
    else $error("sample speed not back at its reset code");
  a_start_single: assert property (convStart |=> !convStart)
    else $error("start held longer than one cycle");
  a_done_single: assert property (convDonePulse |=> !convDonePulse)
    else $error("done pulse held longer than one cycle");
  a_done_masked: assert property (doneEventMask && $past(doneEventMask) |-> !convDonePulse)
    else $error("done pulse seen while masked");
  a_chan_reserved: assert property (regAddr == 8'h2c |-> regRdata[3] == 1'b0 && regRdata[0] == 1'b0)
    else $error("reserved channel bits read nonzero");
endmodule // madc_control_properties

bind madc_control madc_control_properties madc_control_properties_i (.clock(clock), .nrst(nrst),
  .regReset(regReset), .watchdogExpired(watchdogExpired), .tempCompOn(tempCompOn),
  .doneEventMask(doneEventMask), .regAddr(regAddr), .regWrite(regWrite), .regWdata(regWdata),
  .regRdata(regRdata), .convStart(convStart), .sampleSpeed(sampleSpeed),
  .converterActive(converterActive), .convDonePulse(convDonePulse));

//--- dv/madc_conv_model.sv
/*
  behavioural analogue converter: answers each start, quickly or slowly, with the raw sample of the
  selected channel. assumes one start at a time, as the block's scan issues them.
*/
module madc_conv_model (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        nrst,
  // converter side of the block
  input  wire logic [2:0]  convChannel,
  input  wire logic        convStart,
  output logic             convDone,
  output logic      [15:0] convData,
  // bench control
  input  wire logic        slowMode,
  input  wire logic [15:0] rawTable [8]
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] waitCnt_r;
  logic [2:0] chan_r;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      waitCnt_r <= 4'h0;
      chan_r    <= 3'h0;
      convDone  <= 1'b0;
      convData  <= 16'h0000;
    end else begin
      convDone <= 1'b0;
      if (convStart) begin
        chan_r    <= convChannel;
        waitCnt_r <= slowMode ? 4'h9 : 4'h1;
      end else if (waitCnt_r == 4'h1) begin
        convDone  <= 1'b1;
        convData  <= rawTable[chan_r];
        waitCnt_r <= 4'h0;
      end else if (waitCnt_r != 4'h0) begin
        waitCnt_r <= waitCnt_r - 4'h1;
      end else begin
        // data is only good beside the done pulse, so it toggles whenever no conversion is pending
        convData <= ~convData;
      end
    end
  end
endmodule // madc_conv_model

//--- dv/madc_tb.sv
/*
  self-checking bench for the converter control block with a behavioural converter on its far side.
  assumes the checker is bound in from its own file.
*/
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic [7:0] addr; logic [7:0] wdata; logic [7:0] rexp;} madc_row_t;
  logic        clock, nrst, regReset, watchdogExpired, tempCompOn, doneEventMask, oneShotRequest;
  logic [7:0]  regAddr, regWdata, regRdata, rb;
  logic        regWrite, convStart, convDone, converterActive, convDonePulse, slowMode;
  logic [2:0]  convChannel, lastChan;
  logic [1:0]  sampleSpeed;
  logic [15:0] convData;
  logic [15:0] rawTable [8];
  int          mismatches, n_checks, doneCount, startCount, cycles;
  madc_row_t   rows [8] = '{'{8'h2b, 8'hff, 8'hfc}, '{8'h2b, 8'h30, 8'h30}, '{8'h2b, 8'h10, 8'h10},
    '{8'h2b, 8'h00, 8'h00}, '{8'h2c, 8'hff, 8'hf6}, '{8'h2c, 8'h0a, 8'h02}, '{8'h2e, 8'hff, 8'h00},
    '{8'h40, 8'h5a, 8'h00}};

  madc_control madc_control_i (.clock(clock), .nrst(nrst), .regReset(regReset), .watchdogExpired(watchdogExpired),
    .tempCompOn(tempCompOn), .doneEventMask(doneEventMask), .oneShotRequest(oneShotRequest), .regAddr(regAddr),
    .regWrite(regWrite), .regWdata(regWdata), .regRdata(regRdata), .convChannel(convChannel),
    .convStart(convStart), .sampleSpeed(sampleSpeed), .convDone(convDone), .convData(convData),
    .converterActive(converterActive), .convDonePulse(convDonePulse));
  madc_conv_model madc_conv_model_i (.clock(clock), .nrst(nrst), .convChannel(convChannel),
    .convStart(convStart), .convDone(convDone), .convData(convData), .slowMode(slowMode), .rawTable(rawTable));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  always @(posedge clock) begin
    if (convDonePulse === 1'b1) doneCount++;
    if (convStart === 1'b1) begin
      startCount++;
      lastChan = convChannel;
    end
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge clock); regAddr = a; regWdata = d; regWrite = 1'b1;
    @(negedge clock); regWrite = 1'b0;
  endtask
  task automatic rd(logic [7:0] a, output logic [7:0] v);
    @(negedge clock); regAddr = a;
    #1 v = regRdata;
  endtask
  // both bytes read while no scan runs, so they belong to one sample
  task automatic chk_res(logic [7:0] a, logic [15:0] exp);
    logic [7:0] lo, hi;
    rd(a, lo);
    rd(a + 8'h1, hi);
    chk("result", {hi, lo}, exp);
  endtask
  task automatic shot(logic [7:0] ctrl, logic [7:0] chan, logic [15:0] expDone);
    int n;
    wr(madc_pkg::ADDR_CHAN, chan);
    wr(madc_pkg::ADDR_CTRL, ctrl);
    {doneCount, startCount} = '0;
    @(negedge clock); oneShotRequest = 1'b1;
    @(negedge clock); oneShotRequest = 1'b0;
    n = 0;
    while (doneCount == 0 && n < 200) begin
      @(negedge clock); n++;
    end
    chk("done pulses", 16'(doneCount), expDone);
  endtask

  initial begin
    {nrst, regReset, watchdogExpired, tempCompOn, doneEventMask, oneShotRequest, regWrite, slowMode} = '0;
    {regAddr, regWdata} = '0;
    rawTable = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h7fff, 16'hf000, 16'h3000, 16'h8000};
    repeat (16) @(negedge clock);
    nrst = 1'b1;
    rd(madc_pkg::ADDR_CTRL, rb); chk("ctrl reset", rb, 16'h60);
    rd(madc_pkg::ADDR_CHAN, rb); chk("chan reset", rb, 16'(madc_pkg::CHAN_RESET & madc_pkg::CHAN_WMASK));
    chk("active at reset", converterActive, 16'h0);
    chk("speed at reset", sampleSpeed, 16'h2);
    chk_res(madc_pkg::ADDR_IIN_LO, 16'h0000);
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata);
      rd(rows[i].addr, rb); chk("readback", rb, rows[i].rexp);
    end
    // feedback and thermistor kept off throughout, as software must while charging
    slowMode = 1'b1;
    shot(8'hc0, 8'h06, 16'h1);
    chk_res(madc_pkg::ADDR_IIN_LO, 16'h9e58);
    chk_res(madc_pkg::ADDR_BATTERY_CURRENT_LO, 16'h2710);
    chk_res(madc_pkg::ADDR_VIN_LO, 16'h0000);
    chk_res(madc_pkg::ADDR_VBAT_LO, 16'h7530);
    slowMode = 1'b0;
    rawTable[7] = 16'h0000;
    shot(8'hc8, 8'h7e, 16'h1);
    chk("starts in one pass", 16'(startCount), 16'h1);
    chk("last start channel", 16'(lastChan), 16'h7);
    chk_res(madc_pkg::ADDR_IIN_LO, 16'hcf2c);
    chk_res(madc_pkg::ADDR_BATTERY_CURRENT_LO, 16'h2710);
    rawTable[7] = 16'h0100;
    shot(8'hc4, 8'h7e, 16'h1);
    chk_res(madc_pkg::ADDR_IIN_LO, 16'h0100);
    rawTable[7] = 16'h0300;
    shot(8'hcc, 8'h7e, 16'h1);
    chk_res(madc_pkg::ADDR_IIN_LO, 16'h0300);
    doneEventMask = 1'b1;
    shot(8'hc0, 8'h7e, 16'h0);
    doneEventMask = 1'b0;
    rawTable[7] = 16'h0010;
    wr(madc_pkg::ADDR_CTRL, 8'h80);
    {startCount, doneCount} = '0;
    repeat (60) @(negedge clock);
    chk("scan repeats", 16'(startCount > 2), 16'h1);
    chk("no done when continuous", 16'(doneCount), 16'h0);
    wr(madc_pkg::ADDR_CTRL, 8'hc8);
    repeat (30) @(negedge clock);
    chk_res(madc_pkg::ADDR_IIN_LO, 16'h0010);
    watchdogExpired = 1'b1;
    @(negedge clock); watchdogExpired = 1'b0;
    rd(madc_pkg::ADDR_CTRL, rb); chk("ctrl after watchdog", rb, 16'h48);
    chk("active after watchdog", converterActive, 16'h0);
    tempCompOn = 1'b1;
    #1 chk("active by temp comp", converterActive, 16'h1);
    @(negedge clock); tempCompOn = 1'b0; regReset = 1'b1;
    @(negedge clock); regReset = 1'b0;
    rd(madc_pkg::ADDR_CTRL, rb); chk("ctrl after reg reset", rb, 16'h60);
    rd(madc_pkg::ADDR_CHAN, rb); chk("chan after reg reset", rb, 16'(madc_pkg::CHAN_RESET & madc_pkg::CHAN_WMASK));
    chk_res(madc_pkg::ADDR_BATTERY_CURRENT_LO, 16'h0000);
    wrap_up();
  end
endmodule // tb
